// ---- design/ccc_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccc_capture
   import ccc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   ccc_core_if.cap core
);
   logic [1:0] trig;
   logic [1:0] take;
   logic [1:0] armed;
   logic armed_s;
   logic start;
   logic go;
   logic done;
   logic [15:0] ms_left;
   logic [31:0] start_cnt;
   logic [1:0] set_stat;
   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_pt
         assign trig[p] = core.fall_sel[p] ? core.fall[core.src[p]]
            : core.rise[core.src[p]];
         assign take[p] = ~core.sample_mode & core.cap_en & trig[p]
            & (~core.single | armed[p] | core.cap_en_rise);
      end
   endgenerate
   assign start = (core.start_sel == START_POS) ? core.rise[0]
      : (core.start_sel == START_NEG) ? core.fall[0]
      : (core.start_sel == START_REQ) & core.cap_en_rise;
   assign go = core.sample_mode & start & ~core.busy
      & (~core.single | armed_s | core.cap_en_rise);
   assign done = core.busy & core.ms_tick & (ms_left <= 16'h0001);
   assign set_stat = core.sample_mode
      ? {done & core.single, done & ~core.single} : take;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         armed <= 2'b00;
         armed_s <= 1'b0;
      end
      else
      begin
         armed <= core.cap_en_rise ? 2'b11 : (armed & ~take);
         armed_s <= core.cap_en_rise ? 1'b1 : (armed_s & ~go);
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core.busy <= 1'b0;
         ms_left <= 16'h0000;
         start_cnt <= ZERO32;
      end
      else if (go)
      begin
         core.busy <= 1'b1;
         ms_left <= core.sample_ms;
         start_cnt <= core.count;
      end
      else if (done)
      begin
         core.busy <= 1'b0;
      end
      else if (core.busy & core.ms_tick)
      begin
         ms_left <= ms_left - 16'h0001;
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core.cap_a <= ZERO32;
         core.cap_b <= ZERO32;
         core.cap_diff <= ZERO32;
      end
      else if (done)
      begin
         core.cap_a <= start_cnt;
         core.cap_b <= core.count;
         core.cap_diff <= core.count - start_cnt;
      end
      else if (|take)
      begin
         core.cap_a <= take[0] ? core.count : core.cap_a;
         core.cap_b <= take[1] ? core.count : core.cap_b;
         core.cap_diff <= (take[1] ? core.count : core.cap_b)
            - (take[0] ? core.count : core.cap_a);
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core.cap_stat <= 2'b00;
      end
      else
      begin
         core.cap_stat <= ((core.io_refresh | core.cap_en_rise) ? 2'b00
            : core.cap_stat) | set_stat;
      end
   end
endmodule // ccc_capture
`default_nettype wire

// ---- design/ccc_compare.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccc_compare
   import ccc_pkg::*;
(
   ccc_core_if.cmp core
);
   logic [15:0] hit;
   genvar e;
   generate
      for (e = 0; e < N_ENT; e++)
      begin : g_ent
         logic wrap;
         logic above;
         logic below;
         assign wrap = $signed(core.lo[e]) > $signed(core.hi[e]);
         assign above = $signed(core.count) >= $signed(core.lo[e]);
         assign below = $signed(core.count) <= $signed(core.hi[e]);
         assign hit[e] = core.entry_en[e] & (core.band_mode
            ? (wrap ? (above | below) : (above & below))
            : (core.count == core.lo[e]));
      end
   endgenerate
   // Entry 0 is applied last so that it overrides every other entry.
   always_comb
   begin
      logic [31:0] pat;
      logic [15:0] used;
      pat = ZERO32;
      used = 16'h0000;
      for (int k = 0; k < N_ENT; k++)
      begin
         if (core.entry_en[k])
         begin
            used = used | core.up_pat[k][15:0] | core.up_pat[k][31:16];
         end
      end
      // Band flags fall back to OFF outside every band that drives them.
      core.next_flags = core.band_mode ? (core.flags & ~used) : core.flags;
      for (int i = N_ENT - 1; i >= 0; i--)
      begin
         pat = (core.band_mode | core.dir_up) ? core.up_pat[i]
            : core.dn_pat[i];
         if (hit[i])
         begin
            core.next_flags = (core.next_flags & ~pat[31:16]) | pat[15:0];
         end
      end
   end
endmodule // ccc_compare
`default_nettype wire

// ---- design/ccc_core_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ccc_core_if;
   logic [31:0] count;
   logic dir_up;
   logic band_mode;
   logic [15:0] entry_en;
   logic [31:0] lo [16];
   logic [31:0] hi [16];
   logic [31:0] up_pat [16];
   logic [31:0] dn_pat [16];
   logic [15:0] flags;
   logic [15:0] next_flags;
   logic [1:0] rise;
   logic [1:0] fall;
   logic cap_en;
   logic cap_en_rise;
   logic sample_mode;
   logic single;
   logic [1:0] src;
   logic [1:0] fall_sel;
   logic [1:0] start_sel;
   logic [15:0] sample_ms;
   logic ms_tick;
   logic io_refresh;
   logic [31:0] cap_a;
   logic [31:0] cap_b;
   logic [31:0] cap_diff;
   logic [1:0] cap_stat;
   logic busy;
   modport cmp (input count, dir_up, band_mode, entry_en, lo, hi, up_pat,
      dn_pat, flags, output next_flags);
   modport cap (input count, rise, fall, cap_en, cap_en_rise, sample_mode,
      single, src, fall_sel, start_sel, sample_ms, ms_tick, io_refresh,
      output cap_a, cap_b, cap_diff, cap_stat, busy);
endinterface
`default_nettype wire

// ---- design/ccc_pkg.sv ----
package ccc_pkg;
   localparam int N_ENT = 16;
   localparam int AW = 12;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_HOLD = 12'h004;
   localparam logic [11:0] OFF_SAMPLE = 12'h008;
   localparam logic [11:0] OFF_ENTRY_EN = 12'h00c;
   localparam logic [11:0] OFF_STATUS = 12'h010;
   localparam logic [11:0] OFF_CAP_A = 12'h014;
   localparam logic [11:0] OFF_CAP_B = 12'h018;
   localparam logic [11:0] OFF_CAP_DIFF = 12'h01c;
   localparam logic [11:0] OFF_COUNT = 12'h020;
   localparam logic [3:0] ENT_PAGE = 4'h1;
   localparam logic [1:0] ENT_LO = 2'h0;
   localparam logic [1:0] ENT_HI = 2'h1;
   localparam logic [1:0] ENT_UP = 2'h2;
   localparam logic [1:0] ENT_DN = 2'h3;
   localparam int B_BAND = 0;
   localparam int B_ROUTE = 1;
   localparam int B_FON = 3;
   localparam int B_FOFF = 5;
   localparam int B_CAP_EN = 7;
   localparam int B_SAMPLE = 8;
   localparam int B_SINGLE = 9;
   localparam int B_SRC = 10;
   localparam int B_FALL = 12;
   localparam int B_START = 14;
   localparam int CTRL_W = 16;
   localparam int S_FLAGS = 0;
   localparam int S_EXT = 16;
   localparam int S_CAP = 18;
   localparam int S_BUSY = 20;
   localparam logic [1:0] START_POS = 2'h0;
   localparam logic [1:0] START_NEG = 2'h1;
   localparam logic [1:0] START_REQ = 2'h2;
   localparam logic [9:0] HOLD_MAX_MS = 10'h3e8;
   localparam int MS_NS = 1000000;
   localparam int CLK_NS = 8;
   localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

// ---- design/ccc_top.sv ----
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ccc_top
   import ccc_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] count_value,
   input wire logic count_dir_up,
   input wire logic io_refresh,
   input wire logic ctrl_in0,
   input wire logic ctrl_in1,
   output logic ext_out0,
   output logic ext_out1,
   output logic [15:0] match_flags
);
   ccc_core_if core ();
   logic rst_meta;
   logic rst_n;
   logic [CTRL_W-1:0] ctrl;
   logic [9:0] hold_ms;
   logic [15:0] sample_ms;
   logic [15:0] entry_en;
   logic [31:0] ent_lo [16];
   logic [31:0] ent_hi [16];
   logic [31:0] ent_up [16];
   logic [31:0] ent_dn [16];
   logic [31:0] count_prev;
   logic count_step;
   logic [1:0] pin_s1;
   logic [1:0] pin_s2;
   logic [1:0] pin_s3;
   logic [1:0] pin_lvl;
   logic [1:0] pin_rise;
   logic [1:0] pin_fall;
   logic cap_en_d;
   logic cap_en_rise;
   logic [16:0] ms_div;
   logic ms_tick;
   logic [1:0] flag_d;
   logic [9:0] hold_left [2];
   logic [1:0] ext_next;
   logic access;
   logic wr_fire;
   logic [31:0] next_rdata;
   logic next_err;
   logic ent_sel;
   logic [3:0] ent_idx;
   logic [1:0] ent_fld;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // The control pins are filtered: a level is accepted only once the
   // second and third stages agree, which costs four cycles of latency.
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_pin
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pin_s1[g] <= 1'b0;
               pin_s2[g] <= 1'b0;
               pin_s3[g] <= 1'b0;
               pin_lvl[g] <= 1'b0;
               pin_rise[g] <= 1'b0;
               pin_fall[g] <= 1'b0;
            end
            else
            begin
               pin_s1[g] <= g ? ctrl_in1 : ctrl_in0;
               pin_s2[g] <= pin_s1[g];
               pin_s3[g] <= pin_s2[g];
               if (pin_s2[g] == pin_s3[g])
               begin
                  pin_lvl[g] <= pin_s3[g];
               end
               pin_rise[g] <= (pin_s2[g] == pin_s3[g]) & pin_s3[g]
                  & ~pin_lvl[g];
               pin_fall[g] <= (pin_s2[g] == pin_s3[g]) & ~pin_s3[g]
                  & pin_lvl[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ms_div <= 17'h0_0000;
         ms_tick <= 1'b0;
      end
      else if (ms_div == 17'(MS_CYCLES - 1))
      begin
         ms_div <= 17'h0_0000;
         ms_tick <= 1'b1;
      end
      else
      begin
         ms_div <= ms_div + 17'h0_0001;
         ms_tick <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cap_en_d <= 1'b0;
         cap_en_rise <= 1'b0;
      end
      else
      begin
         cap_en_d <= ctrl[B_CAP_EN];
         cap_en_rise <= ctrl[B_CAP_EN] & ~cap_en_d;
      end
   end

   assign count_step = count_value != count_prev;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_prev <= ZERO32;
         match_flags <= 16'h0000;
      end
      else
      begin
         count_prev <= count_value;
         if (count_step)
         begin
            match_flags <= core.next_flags;
         end
      end
   end

   assign core.count = count_value;
   assign core.dir_up = count_dir_up;
   assign core.band_mode = ctrl[B_BAND];
   assign core.entry_en = entry_en;
   assign core.lo = ent_lo;
   assign core.hi = ent_hi;
   assign core.up_pat = ent_up;
   assign core.dn_pat = ent_dn;
   assign core.flags = match_flags;
   assign core.rise = pin_rise;
   assign core.fall = pin_fall;
   assign core.cap_en = ctrl[B_CAP_EN];
   assign core.cap_en_rise = cap_en_rise;
   assign core.sample_mode = ctrl[B_SAMPLE];
   assign core.single = ctrl[B_SINGLE];
   assign core.src = ctrl[B_SRC+1:B_SRC];
   assign core.fall_sel = ctrl[B_FALL+1:B_FALL];
   assign core.start_sel = ctrl[B_START+1:B_START];
   assign core.sample_ms = sample_ms;
   assign core.ms_tick = ms_tick;
   assign core.io_refresh = io_refresh;

   ccc_compare u_cmp (
      .core(core.cmp)
   );

   ccc_capture u_cap (
      .clk(clk),
      .rst_n(rst_n),
      .core(core.cap)
   );

   // The hold is loaded when the flag rises but counts down on the free-running
   // millisecond tick, so the ON time may run up to one millisecond short of the setting.
   generate
      for (g = 0; g < 2; g++)
      begin : g_out
         logic held;
         assign held = ctrl[B_BAND] & (hold_ms != 10'h000);
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               hold_left[g] <= 10'h000;
            end
            else if (held & match_flags[g] & ~flag_d[g])
            begin
               hold_left[g] <= hold_ms;
            end
            else if (ms_tick & (hold_left[g] != 10'h000))
            begin
               hold_left[g] <= hold_left[g] - 10'h001;
            end
         end
         always_comb
         begin
            if (ctrl[B_FON+g])
            begin
               ext_next[g] = 1'b1;
            end
            else if (ctrl[B_FOFF+g] | ~ctrl[B_ROUTE+g])
            begin
               ext_next[g] = 1'b0;
            end
            else if (held)
            begin
               ext_next[g] = hold_left[g] != 10'h000;
            end
            else
            begin
               ext_next[g] = match_flags[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_d <= 2'b00;
         ext_out0 <= 1'b0;
         ext_out1 <= 1'b0;
      end
      else
      begin
         flag_d <= match_flags[1:0];
         ext_out0 <= ext_next[0];
         ext_out1 <= ext_next[1];
      end
   end

   // Every access takes three cycles: pready rises one cycle into the
   // access phase, and the write lands on the edge that samples it.
   assign access = psel & penable;
   assign wr_fire = access & pready & pwrite & ~pslverr;
   assign ent_sel = paddr[11:8] == ENT_PAGE;
   assign ent_idx = paddr[7:4];
   assign ent_fld = paddr[3:2];

   always_comb
   begin
      next_rdata = ZERO32;
      next_err = 1'b0;
      if (ent_sel)
      begin
         unique case (ent_fld)
            ENT_LO: next_rdata = ent_lo[ent_idx];
            ENT_HI: next_rdata = ent_hi[ent_idx];
            ENT_UP: next_rdata = ent_up[ent_idx];
            ENT_DN: next_rdata = ent_dn[ent_idx];
         endcase
         next_err = paddr[1:0] != 2'b00;
      end
      else
      begin
         case (paddr)
            OFF_CTRL: next_rdata = {16'h0000, ctrl};
            OFF_HOLD: next_rdata = {22'h00_0000, hold_ms};
            OFF_SAMPLE: next_rdata = {16'h0000, sample_ms};
            OFF_ENTRY_EN: next_rdata = {16'h0000, entry_en};
            OFF_STATUS: next_rdata = {11'h000, core.busy, core.cap_stat,
               ext_out1, ext_out0, match_flags};
            OFF_CAP_A: next_rdata = core.cap_a;
            OFF_CAP_B: next_rdata = core.cap_b;
            OFF_CAP_DIFF: next_rdata = core.cap_diff;
            OFF_COUNT: next_rdata = count_value;
            default: next_err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= ZERO32;
      end
      else
      begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & next_err;
         if (access & ~pready & ~pwrite)
         begin
            prdata <= next_rdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= 16'h0000;
         hold_ms <= 10'h000;
         sample_ms <= 16'h0001;
         entry_en <= 16'h0000;
      end
      else if (wr_fire & ~ent_sel)
      begin
         if (paddr == OFF_CTRL)
         begin
            ctrl <= pwdata[CTRL_W-1:0];
         end
         if (paddr == OFF_HOLD)
         begin
            hold_ms <= (pwdata[9:0] > HOLD_MAX_MS) ? HOLD_MAX_MS
               : pwdata[9:0];
         end
         if (paddr == OFF_SAMPLE)
         begin
            sample_ms <= pwdata[15:0];
         end
         if (paddr == OFF_ENTRY_EN)
         begin
            entry_en <= pwdata[15:0];
         end
      end
   end

   generate
      for (g = 0; g < N_ENT; g++)
      begin : g_ent
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               ent_lo[g] <= ZERO32;
               ent_hi[g] <= ZERO32;
               ent_up[g] <= ZERO32;
               ent_dn[g] <= ZERO32;
            end
            else if (wr_fire & ent_sel & (ent_idx == 4'(g)))
            begin
               if (ent_fld == ENT_LO)
               begin
                  ent_lo[g] <= pwdata;
               end
               if (ent_fld == ENT_HI)
               begin
                  ent_hi[g] <= pwdata;
               end
               if (ent_fld == ENT_UP)
               begin
                  ent_up[g] <= pwdata;
               end
               if (ent_fld == ENT_DN)
               begin
                  ent_dn[g] <= pwdata;
               end
            end
         end
      end
   endgenerate
endmodule // ccc_top
`default_nettype wire

// ---- sim/ccc_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Counting core stand-in: one step per clock toward the goal, so no
// value in between is skipped, as a real pulse counter behaves.
module ccc_src_model
(
   input wire logic clk,
   input wire logic [31:0] goal,
   output logic [31:0] count_value,
   output logic count_dir_up
);
   logic up;
   assign up = $signed(goal) > $signed(count_value);
   initial count_value = 32'h0000_0000;
   initial count_dir_up = 1'b1;
   always @(posedge clk)
   begin
      if (count_value != goal)
      begin
         count_dir_up <= up;
         count_value <= up ? count_value + 1 : count_value - 1;
      end
   end
endmodule // ccc_src_model
`default_nettype wire

// ---- sim/ccc_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccc_chk
   import ccc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] count_value,
   input wire logic ext_out0,
   input wire logic [15:0] match_flags
);
   logic [6:0] ctl;
   logic hz;
   logic [1:0] qc;
   logic [31:0] cp;
   logic wr;
   assign wr = psel && penable && pready && pwrite;
   // Shadow of the output control and hold fields, taken from APB writes.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctl <= 7'h00;
         hz <= 1'b1;
      end
      else if (wr && paddr == OFF_CTRL)
         ctl <= pwdata[6:0];
      else if (wr && paddr == OFF_HOLD)
         hz <= pwdata[9:0] == 10'h000;
   end
   // Cycles with neither a count change nor a bus access.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         qc <= 2'h0;
      else if (psel || count_value != cp)
         qc <= 2'h0;
      else if (qc != 2'h3)
         qc <= qc + 2'h1;
   end
   always_ff @(posedge clk)
      cp <= count_value;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   a_rdy_time: assert property (psel && !penable |-> ##2 pready)
      else $error("pready not in second access cycle");
   a_rdy_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_unmap: assert property (pready && paddr == 12'h0fc |-> pslverr)
      else $error("no error on unmapped address");
   a_ok_map: assert property (pready && paddr == OFF_SAMPLE |-> !pslverr)
      else $error("error on mapped address");
   a_force_on: assert property (ctl[3] && $past(ctl[3]) |-> ext_out0)
      else $error("forced on output is low");
   a_force_off: assert property (ctl == $past(ctl) && ctl[5] && !ctl[3]
      |-> !ext_out0)
      else $error("forced off output is high");
   a_out_follow: assert property ($stable(ctl) && $stable(hz) && hz &&
      ctl[1] && ctl[5:3] == 3'h0 && $stable(match_flags[0])
      |-> ext_out0 == match_flags[0])
      else $error("output does not follow flag 0");
   a_route_off: assert property ($stable(ctl) && !ctl[1] && !ctl[3]
      |-> !ext_out0)
      else $error("unrouted output is high");
   a_flags_quiet: assert property (qc == 2'h3 |-> $stable(match_flags))
      else $error("flags moved with count still");
   c_err: cover property (pready && pslverr);
   c_ext: cover property (ext_out0 && ctl[1]);
   c_flag: cover property ($rose(match_flags[0]));
endmodule // ccc_chk
bind ccc_top ccc_chk u_ccc_chk (.clk, .reset_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .count_value, .ext_out0,
   .match_flags);
`default_nettype wire

// ---- sim/tb_ccc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ccc_top
   import ccc_pkg::*;
;
   logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic io_refresh = 0, ctrl_in0 = 0, ctrl_in1 = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, goal = 32'h0000_0000;
   logic [31:0] prdata, count_value, r, sd, t, x, y;
   logic pready, pslverr, count_dir_up, ext_out0, ext_out1, e;
   logic [15:0] match_flags;
   int bad_count = 0, num_checks = 0, cyc = 0;
   ccc_top #(.MS_CYCLES(10)) u_ccc_top (.clk, .reset_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .count_value,
      .count_dir_up, .io_refresh, .ctrl_in0, .ctrl_in1, .ext_out0,
      .ext_out1, .match_flags);
   ccc_src_model u_ccc_src_model (.clk, .goal, .count_value, .count_dir_up);
   initial forever #4 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] dif(input logic [31:0] a, b);
      return b - a;
   endfunction
   function automatic logic [11:0] ea(input int i, input logic [1:0] k);
      return 12'h100 + 12'(i * 16 + k * 4);
   endfunction
   task automatic give_verdict();
      $display("checks %0d bad %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic chk(input string s, input logic [31:0] x, g);
      num_checks++;
      if (g !== x)
      begin
         bad_count++;
         $display("BAD %s exp %h got %h", s, x, g);
      end
   endtask
   // Held until pready is seen high at a rising edge, then released.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] x, string s);
      apb(1'b0, a, 32'h0000_0000);
      chk(s, x, r);
   endtask
   task automatic go(input logic [31:0] v);
      goal <= v;
      do @(posedge clk); while (count_value !== v);
      repeat (3) @(posedge clk);
   endtask
   task automatic pin1();
      ctrl_in1 <= 1'b1;
      repeat (10) @(posedge clk);
      ctrl_in1 <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      rc(OFF_HOLD, 32'h0000_0000, "hold");
      rc(OFF_SAMPLE, 32'h0000_0001, "sample");
      rc(12'h0fc, 32'h0000_0000, "unmapped");
      chk("slverr", 32'h0000_0001, 32'(e));
      sd = lfsr(32'h0000_ded9);
      t = 32'(sd[5:0]) + 32'h0000_0014;
      wr(ea(0, ENT_LO), t);
      wr(ea(1, ENT_LO), t);
      wr(ea(0, ENT_UP), 32'h0011_0008);
      wr(ea(0, ENT_DN), 32'h0000_0020);
      wr(ea(1, ENT_UP), 32'h0000_0010);
      wr(OFF_ENTRY_EN, 32'h0000_0003);
      go(t);
      chk("up hit", 32'h0000_0008, 32'(match_flags));
      go(t + 5);
      go(t);
      chk("dn hit", 32'h0000_0028, 32'(match_flags));
      for (int i = 2; i < 4; i++)
      begin
         wr(ea(i, ENT_LO), 32'h0000_00c8);
         wr(ea(i, ENT_HI), 32'h0000_0032);
      end
      wr(ea(2, ENT_UP), 32'h0000_0005);
      wr(ea(3, ENT_UP), 32'h0000_0040);
      wr(OFF_ENTRY_EN, 32'h0000_000c);
      wr(OFF_CTRL, 32'h0000_0003);
      go(32'h0000_012c);
      chk("band hi", 32'h0000_0045, 32'(match_flags & 16'h0045));
      go(32'h0000_0064);
      chk("band out", 32'h0000_0000, 32'(match_flags & 16'h0045));
      chk("ext off", 32'h0000_0000, 32'(ext_out0));
      go(32'h0000_0030);
      chk("band wrap", 32'h0000_0045, 32'(match_flags & 16'h0045));
      chk("ext on", 32'h0000_0001, 32'(ext_out0));
      wr(OFF_HOLD, 32'h0000_0003);
      go(32'h0000_0034);
      go(32'h0000_0031);
      go(32'h0000_0034);
      chk("hold on", 32'h0000_0001, 32'(ext_out0));
      repeat (40) @(posedge clk);
      chk("hold end", 32'h0000_0000, 32'(ext_out0));
      wr(OFF_CTRL, 32'h0000_001b);
      repeat (3) @(posedge clk);
      chk("force on", 32'h0000_0001, 32'(ext_out0));
      chk("force on1", 32'h0000_0001, 32'(ext_out1));
      wr(OFF_CTRL, 32'h0000_0023);
      go(32'h0000_0030);
      chk("force off", 32'h0000_0000, 32'(ext_out0));
      wr(OFF_CTRL, 32'h0000_2080);
      sd = lfsr(sd);
      x = 32'(sd[6:0]);
      go(x);
      ctrl_in0 <= 1'b1;
      repeat (10) @(posedge clk);
      sd = lfsr(sd);
      y = 32'(sd[6:0]);
      go(y);
      ctrl_in0 <= 1'b0;
      repeat (10) @(posedge clk);
      rc(OFF_CAP_A, x, "cap a");
      rc(OFF_CAP_B, y, "cap b");
      rc(OFF_CAP_DIFF, dif(x, y), "diff");
      rc(OFF_STATUS, 32'h000c_006d, "status");
      chk("stat set", 32'h0000_0003, 32'(r[19:18]));
      io_refresh <= 1'b1;
      @(posedge clk);
      io_refresh <= 1'b0;
      rc(OFF_STATUS, 32'h0000_006d, "status");
      chk("stat clr", 32'h0000_0000, 32'(r[19:18]));
      wr(OFF_CTRL, 32'h0000_0400);
      go(x + 3);
      pin1();
      rc(OFF_CAP_A, x, "cap off");
      wr(OFF_CTRL, 32'h0000_0480);
      pin1();
      rc(OFF_CAP_A, x + 3, "cap ctl1");
      wr(OFF_SAMPLE, 32'h0000_0003);
      wr(OFF_CTRL, 32'h0000_0100);
      ctrl_in0 <= 1'b1;
      repeat (8) @(posedge clk);
      go(x + 8);
      repeat (40) @(posedge clk);
      rc(OFF_CAP_A, x + 3, "smp a");
      rc(OFF_CAP_B, x + 8, "smp b");
      rc(OFF_CAP_DIFF, dif(x + 3, x + 8), "smp diff");
      wr(OFF_CTRL, 32'h0000_0600);
      wr(OFF_CTRL, 32'h0000_0680);
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      chk("stat en", 32'h0000_0000, 32'(r[19:18]));
      pin1();
      go(x + 10);
      pin1();
      rc(OFF_CAP_A, x + 8, "single");
      give_verdict();
   end
endmodule // tb_ccc_top
`default_nettype wire
